// ### rtl/mabp_port.sv
// multiplexed address/data bus port: write buffer fifo and the bus sequencer.
// assumes memory answers each datum with a four-phase acknowledge level
// and that the board resolves the two-way pins from the output enables.
// Notes on behaviour
// - address bits 31..4 on upper bus lines
// - active-low byte strobes on lowest four lines
// - control bit keeps strobes inactive during reads
// - same lines carry data after address
// - write data comes from the write buffer
// - single or four-word reads into read buffer
// - lanes from size, port width, byte order
// - low address bits valid per port width
// - exact address, then step for wide datum
// - quad reads count from zero by port step
// - low address pins sampled as reset options
// - diag shows cache miss in address phase
// - diag shows instruction fetch in data phase
// - latch strobe high while address valid
// - signal bus release before memory drives
`timescale 1ns/1ps

module mabp_fifo #(
   parameter int W = 32,
   parameter int D = 4
) (
   input  wire logic         clk,       // system clock
   input  wire logic         rstn,      // async reset, low
   input  wire logic         in_valid,  // push request
   output logic              in_ready,  // room for a word
   input  wire logic [W-1:0] in_data,   // pushed word
   output logic              out_valid, // word available
   input  wire logic         out_ready, // pop request
   output logic [W-1:0]      out_data   // head word
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } mabp_fifo_t;
   mabp_fifo_t    q, d;
   logic [W-1:0]  mem [D];
   logic          push, pop;

   assign in_ready  = (q.cnt != (AW+1)'(D));
   assign out_valid = (q.cnt != '0);
   assign out_data  = mem[q.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointer and count update
   always_comb begin
      d = q;
      if (push) d.wp = (q.wp == AW'(D-1)) ? '0 : q.wp + 1'b1;
      if (pop)  d.rp = (q.rp == AW'(D-1)) ? '0 : q.rp + 1'b1;
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) q <= '0;
      else       q <= d;
   end

   // storage, written without reset
   always_ff @(posedge clk) begin
      if (push) mem[q.wp] <= in_data;
   end
endmodule : mabp_fifo

module mabp_port
   import mabp_pkg::*;
(
   input  wire logic        clk,           // 25 mhz clock
   input  wire logic        rstn,          // async reset, low
   // control registers
   input  wire logic [3:0]  reg_addr,      // byte address
   input  wire logic [31:0] reg_wdata,     // write data
   input  wire logic        reg_wr,        // write strobe
   input  wire logic        reg_rd,        // read strobe
   output logic [31:0]      reg_rdata,     // read data, next cycle
   // transfer requests
   input  wire logic        req_valid,     // request present
   output logic             req_ready,     // request taken
   input  wire logic        req_write,     // 1 write, 0 read
   input  wire logic [31:0] req_addr,      // byte address
   input  wire logic [1:0]  req_size,      // byte, half, word
   input  wire logic        req_quad,      // four-word read
   input  wire logic        req_instr,     // instruction reference
   input  wire logic        req_miss,      // caused by cache miss
   // write buffer fill side
   input  wire logic        wd_valid,      // store word present
   output logic             wd_ready,      // buffer has room
   input  wire logic [31:0] wd_data,       // store word
   // read buffer side
   output logic             rd_valid,      // read word pulse
   output logic [31:0]      rd_data,       // read word
   output logic             rd_last,       // last word of transfer
   // bus pins
   input  wire logic [31:0] ad_in,         // address/data in
   output logic [31:0]      ad_out,        // address/data out
   output logic             ad_oe,         // address/data drive
   input  wire logic [3:0]  low_addr_in,   // low address in (options)
   output logic [3:0]       low_addr_out,  // low address out
   output logic             low_addr_oe,   // low address drive
   output logic             diag,          // diagnostic pin
   output logic             ale,           // address latch strobe
   output logic             read_data_drive_enable, // bus released on reads
   input  wire logic        mem_ack        // memory datum acknowledge
);
   typedef struct packed {
      mabp_state_t st;
      logic [1:0]  cnt;        // settle and address phase counter
      logic [3:0]  opts;       // sampled reset options
      logic [31:0] ctrl;
      logic [31:0] rdata;
      logic [2:0]  ack_s;      // acknowledge synchroniser
      logic        ack;        // confirmed acknowledge level
      logic [95:0] ad_s;       // data pin synchroniser
      logic [11:0] la_s;       // option pin synchroniser
      logic [31:0] addr;
      logic        wr, quad, instr, miss;
      logic [1:0]  size;
      logic [3:0]  lo;         // low address counter
      logic [4:0]  left;       // beats remaining
      logic [31:0] acc;        // read word assembly
      logic        rv, rl;
      logic [31:0] rw;
   } mabp_top_t;
   mabp_top_t   q, d;

   logic        wb_valid, wb_pop;
   logic [31:0] wb_data;
   logic [1:0]  pw, plog, slog;
   logic [3:0]  step, lmask, be_n;
   logic [1:0]  lane;
   logic [4:0]  beats;
   logic [31:0] chunk;
   logic        beat_done, word_end;

   // write buffer holding store data ahead of the bus
   mabp_fifo #(.W(32), .D(MABP_FIFO_DEPTH)) u_wbuf (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (wd_valid),
      .in_ready  (wd_ready),
      .in_data   (wd_data),
      .out_valid (wb_valid),
      .out_ready (wb_pop),
      .out_data  (wb_data)
   );

   // port width, step and lane selection
   always_comb begin
      pw    = q.ctrl[MABP_CTRL_PW_LO +: 2];
      plog  = (pw == MABP_PW_32) ? 2'd2 : (pw == MABP_PW_16) ? 2'd1 : 2'd0;
      slog  = (req_size == MABP_SZ_BYTE) ? 2'd0 : (req_size == MABP_SZ_HALF) ? 2'd1 : 2'd2;
      step  = 4'(4'h1 << plog);
      beats = req_quad ? 5'(5'h10 >> plog)
            : (slog > plog) ? 5'(5'h1 << (slog - plog)) : 5'h1;
      lmask = (q.size == MABP_SZ_BYTE) ? 4'h1 : (q.size == MABP_SZ_HALF) ? 4'h3 : 4'hF;
      lmask = 4'(lmask << q.addr[1:0]);
      if (q.ctrl[MABP_CTRL_BIG_END])
         lmask = {lmask[0], lmask[1], lmask[2], lmask[3]};
      if (q.quad)
         lmask = 4'hF;
      be_n = ~lmask;
      if (!q.wr && q.ctrl[MABP_CTRL_BE_INH])
         be_n = 4'hF;
      // lane holding the current chunk on narrow ports
      if (plog == 2'd2)
         lane = 2'd0;
      else if (q.ctrl[MABP_CTRL_BIG_END])
         lane = 2'(2'd3 - q.lo[1:0] - 2'(step - 4'h1));
      else
         lane = q.lo[1:0];
      chunk = q.ad_s[95:64];
      if (plog == 2'd1) chunk = {16'h0000, chunk[15:0]};
      if (plog == 2'd0) chunk = {24'h00_0000, chunk[7:0]};
      chunk = 32'(chunk << {lane, 3'b000});
   end

   assign beat_done = (q.st == MABP_ST_WAIT) && q.ack;
   assign word_end  = (q.left == 5'h1) || (q.quad && ((q.lo + step) & 4'h3) == 4'h0);
   assign wb_pop    = beat_done && q.wr && (q.left == 5'h1);
   assign req_ready = (q.st == MABP_ST_IDLE) && (!req_write || wb_valid);

   // sequencer and register port
   always_comb begin
      d = q;
      d.rv = 1'b0;
      d.rl = 1'b0;
      // three-stage pin synchronisers; an acknowledge or option change counts when stages two and three agree
      d.ack_s = {q.ack_s[1:0], mem_ack};
      if (q.ack_s[2] == q.ack_s[1]) d.ack = q.ack_s[2];
      d.ad_s = {q.ad_s[63:0], ad_in};
      d.la_s = {q.la_s[7:0], low_addr_in};
      // register access
      d.rdata = 32'h0000_0000;
      if (reg_rd && reg_addr == MABP_CTRL_OFS) d.rdata = q.ctrl;
      if (reg_rd && reg_addr == MABP_STAT_OFS)
         d.rdata = {27'h0, (q.st != MABP_ST_IDLE), q.opts};
      if (reg_wr && reg_addr == MABP_CTRL_OFS) d.ctrl = reg_wdata;
      case (q.st)
         MABP_ST_CFG: begin
            // pins stay inputs until the options have crossed the synchroniser
            if (q.cnt == MABP_CFG_SETTLE && q.la_s[11:8] == q.la_s[7:4]) begin
               d.opts = q.la_s[11:8];
               if (q.la_s[11 - (3 - MABP_OPT_ROM16)])
                  d.ctrl[MABP_CTRL_PW_LO +: 2] = MABP_PW_16;
               else if (q.la_s[11 - (3 - MABP_OPT_ROM8)])
                  d.ctrl[MABP_CTRL_PW_LO +: 2] = MABP_PW_8;
               d.st = MABP_ST_IDLE;
            end else if (q.cnt != MABP_CFG_SETTLE) begin
               d.cnt = q.cnt + 2'd1;
            end
         end
         MABP_ST_IDLE: begin
            if (req_valid && req_ready) begin
               d.addr  = req_addr;
               d.wr    = req_write;
               d.quad  = req_quad && !req_write;
               d.size  = req_size;
               d.instr = req_instr;
               d.miss  = req_miss;
               d.left  = beats;
               d.lo    = (req_quad && !req_write) ? 4'h0 : req_addr[3:0];
               d.acc   = 32'h0000_0000;
               d.cnt   = q.opts[MABP_OPT_XHOLD] ? MABP_ALE_XHOLD_CYC : MABP_ALE_CYC;
               d.st    = MABP_ST_ADDR;
            end
         end
         MABP_ST_ADDR: begin
            if (q.cnt > 2'd1) d.cnt = q.cnt - 2'd1;
            else d.st = q.wr ? MABP_ST_WAIT : MABP_ST_TURN;
         end
         MABP_ST_TURN: begin
            d.st = MABP_ST_WAIT;
         end
         MABP_ST_WAIT: begin
            if (q.ack) begin
               if (!q.wr) begin
                  d.acc = q.acc | chunk;
                  if (word_end) begin
                     d.rv  = 1'b1;
                     d.rw  = q.acc | chunk;
                     d.rl  = (q.left == 5'h1);
                     d.acc = 32'h0000_0000;
                  end
               end
               d.lo   = q.lo + step;
               d.left = q.left - 5'h1;
               d.st   = MABP_ST_REL;
            end
         end
         MABP_ST_REL: begin
            if (!q.ack) d.st = (q.left == 5'h0) ? MABP_ST_IDLE : MABP_ST_WAIT;
         end
         default: d.st = MABP_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q      <= '0;
         q.st   <= MABP_ST_CFG;
         q.ctrl <= MABP_CTRL_RST;
      end else begin
         q <= d;
      end
   end

   // pin drive
   always_comb begin
      ale    = (q.st == MABP_ST_ADDR);
      ad_oe  = (q.st == MABP_ST_ADDR) || (q.wr && (q.st == MABP_ST_WAIT || q.st == MABP_ST_REL));
      ad_out = {q.addr[31:4], be_n};
      if (q.st != MABP_ST_ADDR)
         ad_out = (plog == 2'd2) ? wb_data : 32'(wb_data >> {lane, 3'b000});
      read_data_drive_enable = !q.wr &&
         (q.st == MABP_ST_WAIT || q.st == MABP_ST_REL);
      low_addr_oe  = (q.st != MABP_ST_CFG);
      low_addr_out = q.lo;
      if (q.st == MABP_ST_ADDR) diag = !q.wr && q.miss;
      else                      diag = !q.wr && q.instr;
   end

   assign reg_rdata = q.rdata;
   assign rd_valid  = q.rv;
   assign rd_data   = q.rw;
   assign rd_last   = q.rl;
endmodule : mabp_port

// ### rtl/mabp_pkg.sv
// package for the multiplexed address/data bus port: register map,
// reset values, encodings, machine states and timing constants.
// assumes a single 25 MHz clock shared by every user of the package.
package mabp_pkg;
   // register map of the control port (byte addresses)
   localparam logic [3:0]  MABP_CTRL_OFS      = 4'h0;
   localparam logic [3:0]  MABP_STAT_OFS      = 4'h4;
   localparam logic [31:0] MABP_CTRL_RST      = 32'h0000_0000;
   // control register fields
   localparam int          MABP_CTRL_BE_INH   = 0;   // byte strobes held off on reads
   localparam int          MABP_CTRL_PW_LO    = 1;   // port width, two bits
   localparam int          MABP_CTRL_BIG_END  = 3;   // big endian byte order
   // status register fields
   localparam int          MABP_STAT_CFG_LO   = 0;   // four reset option bits
   localparam int          MABP_STAT_BUSY     = 4;
   // reset option bits as sampled on the low address pins
   localparam int          MABP_OPT_ROM16     = 3;
   localparam int          MABP_OPT_ROM8      = 2;
   localparam int          MABP_OPT_RSVD      = 1;
   localparam int          MABP_OPT_XHOLD     = 0;
   // port width and datum size encodings
   localparam logic [1:0]  MABP_PW_32         = 2'h0;
   localparam logic [1:0]  MABP_PW_16         = 2'h1;
   localparam logic [1:0]  MABP_PW_8          = 2'h2;
   localparam logic [1:0]  MABP_SZ_BYTE       = 2'h0;
   localparam logic [1:0]  MABP_SZ_HALF       = 2'h1;
   localparam logic [1:0]  MABP_SZ_WORD       = 2'h2;
   // timing
   localparam int          MABP_CLK_NS        = 40;
   localparam int          MABP_ALE_NS        = 40;  // least address phase
   localparam int          MABP_ALE_XHOLD_NS  = 80;  // least phase with extended hold
   localparam logic [1:0]  MABP_ALE_CYC       = 2'((MABP_ALE_NS + MABP_CLK_NS - 1) / MABP_CLK_NS);
   localparam logic [1:0]  MABP_ALE_XHOLD_CYC =
      2'((MABP_ALE_XHOLD_NS + MABP_CLK_NS - 1) / MABP_CLK_NS);
   localparam logic [1:0]  MABP_CFG_SETTLE    = 2'h3; // cycles for option pins to sync
   localparam int          MABP_FIFO_DEPTH    = 4;

   typedef enum logic [2:0] {
      MABP_ST_CFG  = 3'b000,  // low address pins are inputs
      MABP_ST_IDLE = 3'b001,
      MABP_ST_ADDR = 3'b010,  // address phase, latch strobe high
      MABP_ST_TURN = 3'b011,  // read turnaround, bus released
      MABP_ST_WAIT = 3'b100,  // wait for memory acknowledge
      MABP_ST_REL  = 3'b101   // wait for acknowledge to drop
   } mabp_state_t;
endpackage : mabp_pkg

// ### verif/mabp_chk.sv
// checker for the bus port: address phase, turnaround, diag and read pulses.
// assumes the option pins select the single-cycle address phase.
`timescale 1ns/1ps

module mabp_chk (
   input wire logic        clk,                    // clock
   input wire logic        rstn,                   // async reset, low
   input wire logic        req_valid,              // request present
   input wire logic        req_ready,              // request taken
   input wire logic        req_write,              // write request
   input wire logic [31:0] req_addr,               // request address
   input wire logic        req_quad,               // quad read
   input wire logic        req_miss,               // cache miss
   input wire logic [31:0] ad_out,                 // bus out
   input wire logic        ad_oe,                  // bus drive
   input wire logic [3:0]  low_addr_out,           // low address
   input wire logic        low_addr_oe,            // low address drive
   input wire logic        diag,                   // diagnostic pin
   input wire logic        ale,                    // latch strobe
   input wire logic        read_data_drive_enable, // bus released
   input wire logic        rd_valid                // read word pulse
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // request taken, and read request taken
   sequence s_take;
      req_valid && req_ready;
   endsequence
   sequence s_take_rd;
      req_valid && req_ready && !req_write;
   endsequence

   // address phase, turnaround and data phase
   AST_ALE_NEXT: assert property (s_take |=> ale)
      else $error("latch strobe missing after request");
   AST_ADDR_HI: assert property (s_take |=> ad_oe && ad_out[31:4] == $past(req_addr[31:4]))
      else $error("high address wrong in address phase");
   AST_TURN: assert property (s_take_rd |=> ale ##1 (!ale && !ad_oe))
      else $error("bus not turned after read address");
   AST_ALE_END: assert property ($rose(ale) |-> ##[1:2] !ale)
      else $error("latch strobe too long");
   AST_REL: assert property (read_data_drive_enable |-> !ad_oe && !ale)
      else $error("bus driven or strobe high while released");
   AST_DIAG_MISS: assert property (s_take_rd |=> diag == $past(req_miss))
      else $error("diag does not show miss");
   AST_QUAD_ZERO: assert property (req_valid && req_ready && !req_write && req_quad
      |=> low_addr_out == 4'h0)
      else $error("quad count does not start at zero");
   AST_OPT_IN: assert property (!low_addr_oe |-> !ale && !ad_oe)
      else $error("transfer while option pins are inputs");
   AST_RD_PULSE: assert property (rd_valid |=> !rd_valid)
      else $error("read word pulse too long");
endmodule : mabp_chk

// ### verif/mabp_mem.sv
// partner memory: latches the address, answers each datum with a level ack.
// assumes the bench tells it how many datums a transfer has.
`timescale 1ns/1ps

module mabp_mem (
   input  wire logic        clk,                    // clock
   input  wire logic        ale,                    // latch strobe
   input  wire logic        read_data_drive_enable, // bus released
   input  wire logic        diag,                   // diagnostic pin
   input  wire logic [31:0] ad_out,                 // bus from device
   input  wire logic [3:0]  low_addr_out,           // low address
   output logic [31:0]      ad_in,                  // bus to device
   output logic             mem_ack                 // datum acknowledge
);
   logic [31:0] lat_q;  // latched address
   logic [31:0] dat;    // read data
   logic        drv;    // memory drives the bus
   logic [3:0]  lo [4]; // low address per datum
   logic [31:0] wr [4]; // bus per datum
   logic        dg [4]; // diag per datum

   initial begin
      drv = 1'b0;
      dat = 32'h0000_0000;
      mem_ack = 1'b0;
   end
   // transparent address latch
   always_latch if (ale) lat_q <= ad_out;
   // released bus shows the inverse of the last value, never a stale copy
   assign ad_in = drv ? dat : ~dat;

   // serve n datums; on reads drive only once the device released the bus
   task automatic serve(input int n, input logic rd, output logic ok);
      int t;
      ok = 1'b1;
      for (int i = 0; i < n; i++) begin
         t = 0;
         while (rd && read_data_drive_enable !== 1'b1 && t < 60) begin
            @(posedge clk);
            t++;
         end
         if (t >= 60) ok = 1'b0;
         @(posedge clk);
         dat <= 32'h1234_5600 | {28'h0, low_addr_out};
         drv <= rd;
         repeat (4) @(posedge clk);
         mem_ack <= 1'b1;
         lo[i] = low_addr_out;
         wr[i] = ad_out;
         dg[i] = diag;
         repeat (8) @(posedge clk);
         mem_ack <= 1'b0;
         repeat (8) @(posedge clk);
      end
      drv <= 1'b0;
   endtask : serve
endmodule : mabp_mem

// ### verif/tb.sv
// self-checking bench for the bus port: registers, writes, reads, quad reads.
// assumes the option pins select only the reserved option.
`timescale 1ns/1ps

module tb;
   import mabp_pkg::*;
   localparam logic [3:0] OPTS = 4'h2; // reserved option only
   logic        clk, rstn, reg_wr, reg_rd, req_valid, req_write, req_quad, req_instr;
   logic        req_miss, wd_valid, req_ready, wd_ready, rd_valid, rd_last, ad_oe;
   logic        low_addr_oe, diag, ale, rden, mem_ack, ok, dg;
   logic [1:0]  req_size;
   logic [3:0]  reg_addr, low_addr_out;
   logic [31:0] reg_wdata, req_addr, wd_data, reg_rdata, rd_data, ad_in, ad_out, ahi;
   wire  [3:0]  low_pins; // resolved low address pins
   logic [31:0] got [$];
   logic [31:0] lasts [$]; // last-word flag beside each read word
   int          n_mismatch, comparisons;

   mabp_port dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_size(req_size),
      .req_quad(req_quad), .req_instr(req_instr), .req_miss(req_miss), .wd_valid(wd_valid),
      .wd_ready(wd_ready), .wd_data(wd_data), .rd_valid(rd_valid), .rd_data(rd_data),
      .rd_last(rd_last), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
      .low_addr_in(low_pins), .low_addr_out(low_addr_out), .low_addr_oe(low_addr_oe),
      .diag(diag), .ale(ale), .read_data_drive_enable(rden), .mem_ack(mem_ack));
   mabp_mem m (.clk(clk), .ale(ale), .read_data_drive_enable(rden), .diag(diag),
      .ad_out(ad_out), .low_addr_out(low_addr_out), .ad_in(ad_in), .mem_ack(mem_ack));

   // option pins pulled to the option level while the device does not drive
   assign low_pins = low_addr_oe ? low_addr_out : OPTS;
   // collect assembled read words
   always @(posedge clk) begin
      if (rd_valid === 1'b1) begin
         got.push_back(rd_data);
         lasts.push_back({31'h0, rd_last});
      end
   end
   // clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic summarize;
      if (n_mismatch == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic give_up(input int t);
      if (t >= 60) begin
         n_mismatch++;
         summarize();
      end
   endtask : give_up
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(reg_rdata, e);
      @(posedge clk);
   endtask : reg_read
   task automatic push(input logic [31:0] d);
      int t;
      wd_valid <= 1'b1;
      wd_data <= d;
      t = 0;
      // ready is looked at on the falling edge, where it is settled
      do begin @(negedge clk); t++; end while (wd_ready !== 1'b1 && t < 60);
      @(posedge clk);
      wd_valid <= 1'b0;
      give_up(t);
   endtask : push
   // one transfer: request, address phase capture, then memory service
   task automatic xfer(input logic w, input logic [31:0] a, input logic [1:0] sz,
                       input logic q, input logic mi, input int n);
      int t;
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_size <= sz;
      req_quad <= q;
      req_miss <= mi;
      req_instr <= ~mi;
      t = 0;
      // ready is looked at on the falling edge; the take is the next rising edge
      do begin @(negedge clk); t++; end while (req_ready !== 1'b1 && t < 60);
      @(posedge clk);
      req_valid <= 1'b0;
      give_up(t);
      @(negedge clk);
      chk({31'h0, ale}, 32'h1);
      ahi = ad_out;
      dg = diag;
      m.serve(n, !w, ok);
      chk({31'h0, ok}, 32'h1);
      @(posedge clk);
   endtask : xfer

   initial begin
      {rstn, reg_wr, reg_rd, req_valid, req_write, req_quad, req_instr, req_miss} = '0;
      {wd_valid, req_size, reg_addr, reg_wdata, req_addr, wd_data} = '0;
      repeat (2) @(posedge clk);
      chk({31'h0, low_addr_oe}, 32'h0);
      rstn <= 1'b1;
      repeat (10) @(posedge clk);
      reg_read(MABP_CTRL_OFS, MABP_CTRL_RST);
      reg_read(MABP_STAT_OFS, {28'h0, OPTS});
      reg_read(4'h8, 32'h0000_0000);
      // word write: all strobes active, exact low address, buffered data
      push(32'hDEAD_BEEF);
      xfer(1'b1, 32'h0000_1238, MABP_SZ_WORD, 1'b0, 1'b0, 1);
      chk(ahi, 32'h0000_1230);
      chk(m.lat_q, 32'h0000_1230);
      chk(m.wr[0], 32'hDEAD_BEEF);
      chk({28'h0, m.lo[0]}, 32'h8);
      // byte write in both byte orders picks the lane
      for (int e = 0; e < 2; e++) begin
         reg_write(MABP_CTRL_OFS, {28'h0, e[0], 3'h0});
         push(32'h0000_5A00);
         xfer(1'b1, 32'h0000_4561, MABP_SZ_BYTE, 1'b0, 1'b0, 1);
         chk(ahi, (e == 1) ? 32'h0000_456B : 32'h0000_456D);
      end
      // reads with strobes normal, then held off
      for (int s = 0; s < 2; s++) begin
         reg_write(MABP_CTRL_OFS, {31'h0, s[0]});
         xfer(1'b0, 32'h0000_2004, MABP_SZ_WORD, 1'b0, ~s[0], 1);
         chk(ahi, (s == 1) ? 32'h0000_200F : 32'h0000_2000);
         chk({31'h0, dg}, {31'h0, ~s[0]});
         chk({31'h0, m.dg[0]}, {31'h0, s[0]});
         chk(got.pop_front(), 32'h1234_5604);
         chk(lasts.pop_front(), 32'h1);
      end
      // quad read counts from zero by word
      reg_write(MABP_CTRL_OFS, 32'h0000_0000);
      xfer(1'b0, 32'h0000_3008, MABP_SZ_WORD, 1'b1, 1'b0, 4);
      for (int i = 0; i < 4; i++) begin
         chk({28'h0, m.lo[i]}, 32'(4 * i));
         chk(got.pop_front(), 32'h1234_5600 + 32'(4 * i));
         chk(lasts.pop_front(), (i == 3) ? 32'h1 : 32'h0);
      end
      // word read on a 16-bit port: two steps, halves assembled; strobes ignored
      reg_write(MABP_CTRL_OFS, {29'h0, MABP_PW_16, 1'b0});
      reg_read(MABP_CTRL_OFS, 32'h0000_0002);
      xfer(1'b0, 32'h0000_5000, MABP_SZ_WORD, 1'b0, 1'b0, 2);
      chk({28'h0, m.lo[1]}, 32'h2);
      chk(got.pop_front(), 32'h5602_5600);
      chk(lasts.pop_front(), 32'h1);
      summarize();
   end
endmodule : tb

bind mabp_port mabp_chk u_chk (.clk(clk), .rstn(rstn), .req_valid(req_valid),
   .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_quad(req_quad),
   .req_miss(req_miss), .ad_out(ad_out), .ad_oe(ad_oe), .low_addr_out(low_addr_out),
   .low_addr_oe(low_addr_oe), .diag(diag), .ale(ale),
   .read_data_drive_enable(read_data_drive_enable), .rd_valid(rd_valid));
